// ---- hw/hvac_map_defines.vh ----
// Purpose: Offsets, field positions, reset values and encodings for the setpoint map.
// Assumes: AXI4-Lite register bus, 32-bit data, one aligned word per register.
// Notes:   Temperatures are signed integer degrees in eight bits.
`ifndef HVAC_MAP_DEFINES_VH
`define HVAC_MAP_DEFINES_VH
`define NUM_UNITS        4
`define UNIT_BITS        2
`define SP_MIN           8'shf1
`define SP_MAX           8'sh3c
`define AMB_MIN          8'shdd
`define AMB_MAX          8'sh5c
`define SP_RESET         8'h16
`define UNIT_STRIDE      12'h020
`define OFS_USER_SP      12'h000
`define OFS_USER_AMB     12'h004
`define OFS_UNIT_SP      12'h008
`define OFS_UNIT_AMB     12'h00c
`define OFS_FAN          12'h010
`define OFS_FILTER       12'h014
`define OFS_FAULT        12'h018
`define OFS_LOCKS        12'h01c
`define OFS_CENTRAL      12'h400
`define OFS_CENTRAL_SP   12'h404
`define OFS_LINK         12'h408
`define OFS_UNIT_IN      12'h40c
`define LINK_NO_COMM     16'h0100
`define MODE_COOL        3'h0
`define MODE_HEAT        3'h1
`define MODE_FAN         3'h2
`define FAN_AUTO         2'h0
`define BIT_FILT_RESET   1
`define BIT_POWER        0
`define BIT_MODE         1
`define BIT_FAN          4
`define BIT_LOCK         8
`define BIT_CEN_SP_WR    16
`endif

// ---- hw/setpoint_calc.v ----
// Purpose: Virtual setpoint calculation for one indoor unit.
// Assumes: Signed integer degrees; inputs from same clock domain.
// Notes:   Purely combinational; the caller registers the result.
`timescale 1ns/1ns
`include "hvac_map_defines.vh"
module setpoint_calc (
  input  wire [7:0] user_sp_i,
  input  wire [7:0] user_amb_i,
  input  wire [7:0] unit_amb_i,
  input  wire       sp_written_i,
  input  wire       amb_written_i,
  output wire       apply_o,
  output wire [7:0] target_o
);
  localparam [7:0] SP_LO = `SP_MIN;
  localparam [7:0] SP_HI = `SP_MAX;
  wire signed [9:0] diff;
  wire signed [9:0] virt;
  wire signed [9:0] lo_ext;
  wire signed [9:0] hi_ext;
  // Range ends are widened by sign so that the clamp compares like with like.
  assign lo_ext = {{2{SP_LO[7]}}, SP_LO};
  assign hi_ext = {{2{SP_HI[7]}}, SP_HI};
  // Setpoint minus the gap between user ambient and probe, in ten bits to avoid overflow.
  assign diff = $signed({{2{user_amb_i[7]}}, user_amb_i}) - $signed({{2{unit_amb_i[7]}}, unit_amb_i});
  assign virt = $signed({{2{user_sp_i[7]}}, user_sp_i}) - diff;
  // Without a user ambient the setpoint passes unchanged.
  assign target_o = !amb_written_i ? user_sp_i :
                    (virt < lo_ext) ? `SP_MIN :
                    (virt > hi_ext) ? `SP_MAX : virt[7:0];
  assign apply_o  = sp_written_i;
endmodule

// ---- hw/onehot_dec.v ----
// Purpose: Binary to one-hot decoder for fan and mode status objects.
// Assumes: Index below width.
// Notes:   Exactly one output bit is high for a valid index.
`timescale 1ns/1ns
module onehot_dec #(
  parameter W = 4
) (
  input  wire [2:0]   idx_i,
  output wire [W-1:0] onehot_o
);
  genvar g;
  // One compare per position keeps all bits updated together on any change.
  generate
    for (g = 0; g < W; g = g + 1) begin : bit_g
      localparam [2:0] POS = g;
      assign onehot_o[g] = (idx_i == POS);
    end
  endgenerate
endmodule

// ---- hw/hvac_datapoint_setpoint_map.v ----
// Purpose: Maps bus objects onto indoor unit control state behind an AXI4-Lite slave.
// Assumes: Unit side values arrive as plain ports on sys_clk_i via the pin synchronisers.
// Notes:   Temperatures are signed integer degrees; float coding is done by bus firmware.
`timescale 1ns/1ns
`include "hvac_map_defines.vh"
module hvac_datapoint_setpoint_map (
  input  wire        sys_clk_i,
  input  wire        reset_i,
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [31:0] unit_ambient_probe_i,
  input  wire [31:0] unit_fault_value_i,
  input  wire [3:0]  filter_sign_i,
  input  wire [15:0] first_link_status_i,
  input  wire [15:0] second_link_status_i,
  output reg  [31:0] virtual_setpoint_out_o,
  output reg  [3:0]  unit_power_o,
  output reg  [11:0] unit_mode_o,
  output reg  [7:0]  unit_fan_o,
  output reg  [19:0] unit_locks_o,
  output reg  [3:0]  filter_clear_o
);
  // Decode a unit index from address bits 6:5 anywhere below the central block, or all ones from 0x400 up.
  function [2:0] unit_of;
    input [11:0] a;
    begin
      unit_of = (a < `OFS_CENTRAL) ? {1'b0, a[6:5]} : 3'h7;
    end
  endfunction

  // Synchronised unit side pins, user objects and held write channel words.
  reg  [31:0] amb_s1_q, amb_s2_q, flt_s1_q, flt_s2_q;
  reg  [3:0]  fs_s1_q, fs_s2_q;
  reg  [15:0] l1_s1_q, l1_s2_q, l2_s1_q, l2_s2_q;
  reg  [7:0]  user_sp_q  [0:`NUM_UNITS-1];
  reg  [7:0]  user_amb_q [0:`NUM_UNITS-1];
  reg  [3:0]  sp_wr_q, amb_wr_q;
  reg  [11:0] aw_addr_q;
  reg  [31:0] w_data_q;
  reg  [3:0]  w_strb_q;
  reg         aw_full_q, w_full_q;
  wire        do_write;
  wire [11:0] ofs;
  wire [2:0]  wu;
  wire [7:0]  wtemp;
  wire        sp_ok, amb_ok, csp_ok;
  wire [7:0]  tgt   [0:`NUM_UNITS-1];
  wire [3:0]  apply;
  wire [3:0]  fan_oh [0:`NUM_UNITS-1];
  wire [4:0]  mode_oh [0:`NUM_UNITS-1];
  reg  [31:0] rd_d;
  reg  [2:0]  ru;
  reg  [11:0] rofs;
  integer     i;
  integer     u;

  // Two flops on every pin from the unit side before any logic looks at it.
  // The values are slow levels, so a word caught mid-change settles a cycle later.
  always @(posedge sys_clk_i) begin
    amb_s1_q <= unit_ambient_probe_i;
    amb_s2_q <= amb_s1_q;
    flt_s1_q <= unit_fault_value_i;
    flt_s2_q <= flt_s1_q;
    fs_s1_q  <= filter_sign_i;
    fs_s2_q  <= fs_s1_q;
    l1_s1_q  <= first_link_status_i;
    l1_s2_q  <= l1_s1_q;
    l2_s1_q  <= second_link_status_i;
    l2_s2_q  <= l2_s1_q;
  end

  // Write channel capture; address and data may arrive in either order.
  assign s_axi_awready = !aw_full_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_full_q && !s_axi_bvalid;
  assign do_write      = aw_full_q && w_full_q;
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      aw_full_q    <= 1'b0;
      w_full_q     <= 1'b0;
      aw_addr_q    <= 12'h000;
      w_data_q     <= 32'h0;
      w_strb_q     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb; // The master may drop its strobe once W is taken.
      end
      if (do_write) begin
        aw_full_q    <= 1'b0;
        w_full_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wu == 3'h7 && aw_addr_q != `OFS_CENTRAL && aw_addr_q != `OFS_CENTRAL_SP)
                        ? 2'h2 : 2'h0;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Fields of the held write; they stand still for as long as do_write is high.
  assign wu     = unit_of(aw_addr_q);
  assign ofs    = aw_addr_q & (`UNIT_STRIDE - 12'h001);
  assign wtemp  = w_data_q[7:0];
  // Out-of-range temperatures are dropped so the held value stays legal.
  assign sp_ok  = ($signed(wtemp) >= `SP_MIN) && ($signed(wtemp) <= `SP_MAX);
  assign amb_ok = ($signed(wtemp) >= `AMB_MIN) && ($signed(wtemp) <= `AMB_MAX);
  assign csp_ok = sp_ok && w_data_q[15:8] == {8{wtemp[7]}};

  // Register file writes: per unit objects and central objects.
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      sp_wr_q        <= 4'h0;
      amb_wr_q       <= 4'h0;
      unit_power_o   <= 4'h0;
      unit_mode_o    <= 12'h0;
      unit_fan_o     <= 8'h0;
      unit_locks_o   <= 20'h0;
      filter_clear_o <= 4'h0;
      for (i = 0; i < `NUM_UNITS; i = i + 1) begin
        user_sp_q[i]  <= `SP_RESET;
        user_amb_q[i] <= 8'h00;
      end
    end else begin
      filter_clear_o <= 4'h0;
      if (do_write && wu != 3'h7 && w_strb_q[0]) begin
        case (ofs)
          `OFS_USER_SP: if (sp_ok) begin
            user_sp_q[wu[1:0]] <= wtemp;
            sp_wr_q[wu[1:0]]   <= 1'b1;
          end
          `OFS_USER_AMB: if (amb_ok) begin
            user_amb_q[wu[1:0]] <= wtemp;
            amb_wr_q[wu[1:0]]   <= 1'b1;
          end
          `OFS_FAN: begin
            unit_fan_o[wu[1:0]*2 +: 2]  <= w_data_q[1:0];
            unit_mode_o[wu[1:0]*3 +: 3] <= (w_data_q[10:8] > 3'h4) ? 3'h4 : w_data_q[10:8];
            unit_power_o[wu[1:0]]       <= w_data_q[16];
          end
          `OFS_FILTER: filter_clear_o[wu[1:0]] <= w_data_q[`BIT_FILT_RESET];
          `OFS_LOCKS:  unit_locks_o[wu[1:0]*5 +: 5] <= w_data_q[4:0];
          default: ;
        endcase
      end
      // Central objects fan out to every unit in the same edge.
      if (do_write && aw_addr_q == `OFS_CENTRAL) begin
        for (i = 0; i < `NUM_UNITS; i = i + 1) begin
          unit_power_o[i]        <= w_data_q[`BIT_POWER];
          unit_mode_o[i*3 +: 3]  <= {2'b00, w_data_q[`BIT_MODE]};
          unit_fan_o[i*2 +: 2]   <= w_data_q[`BIT_FAN +: 2];
          unit_locks_o[i*5 +: 5] <= w_data_q[`BIT_LOCK +: 5];
        end
      end
      if (do_write && aw_addr_q == `OFS_CENTRAL_SP && csp_ok) begin
        for (i = 0; i < `NUM_UNITS; i = i + 1) begin
          user_sp_q[i] <= wtemp;
          sp_wr_q[i]   <= 1'b1;
        end
      end
    end
  end

  // Per unit calculation and one-hot status decoders.
  genvar g;
  generate
    for (g = 0; g < `NUM_UNITS; g = g + 1) begin : unit_g
      setpoint_calc u_calc (
        .user_sp_i     (user_sp_q[g]),
        .user_amb_i    (user_amb_q[g]),
        .unit_amb_i    (amb_s2_q[g*8 +: 8]),
        .sp_written_i  (sp_wr_q[g]),
        .amb_written_i (amb_wr_q[g]),
        .apply_o       (apply[g]),
        .target_o      (tgt[g])
      );
      onehot_dec #(.W(4)) u_fan (
        .idx_i    ({1'b0, unit_fan_o[g*2 +: 2]}),
        .onehot_o (fan_oh[g])
      );
      onehot_dec #(.W(5)) u_mode (
        .idx_i    (unit_mode_o[g*3 +: 3]),
        .onehot_o (mode_oh[g])
      );
    end
  endgenerate

  // User objects, the central setpoint and the unit probe steer the target; fan mode freezes it.
  // One process owns the whole word so that every byte has a single driver.
  // A target written during fan mode is taken up once the mode changes.
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      for (u = 0; u < `NUM_UNITS; u = u + 1) begin
        virtual_setpoint_out_o[u*8 +: 8] <= `SP_RESET;
      end
    end else begin
      for (u = 0; u < `NUM_UNITS; u = u + 1) begin
        if (apply[u] && unit_mode_o[u*3 +: 3] != `MODE_FAN) begin
          virtual_setpoint_out_o[u*8 +: 8] <= tgt[u];
        end
      end
    end
  end

  // Read channel: one outstanding read, answer one cycle after acceptance.
  assign s_axi_arready = !s_axi_rvalid;
  always @* begin
    ru   = unit_of(s_axi_araddr);
    rofs = s_axi_araddr & (`UNIT_STRIDE - 12'h001);
    rd_d = 32'h0;
    if (ru != 3'h7) begin
      case (rofs)
        `OFS_UNIT_SP:  rd_d = {{24{virtual_setpoint_out_o[ru[1:0]*8+7]}},
                               virtual_setpoint_out_o[ru[1:0]*8 +: 8]};
        `OFS_UNIT_AMB: rd_d = {{24{amb_s2_q[ru[1:0]*8+7]}}, amb_s2_q[ru[1:0]*8 +: 8]};
        `OFS_USER_AMB: rd_d = amb_wr_q[ru[1:0]] ? 32'h0 :
                              {{24{amb_s2_q[ru[1:0]*8+7]}}, amb_s2_q[ru[1:0]*8 +: 8]};
        `OFS_FAN:      rd_d = {15'h0, unit_power_o[ru[1:0]], 5'h0,
                               unit_mode_o[ru[1:0]*3 +: 3], 6'h0, unit_fan_o[ru[1:0]*2 +: 2]};
        `OFS_FILTER:   rd_d = {30'h0, 1'b0, fs_s2_q[ru[1:0]]};
        `OFS_FAULT:    rd_d = {16'h0, flt_s2_q[ru[1:0]*8 +: 8] == 8'h0 ? 16'h0 :
                               {8'h0, flt_s2_q[ru[1:0]*8 +: 8]}};
        `OFS_LOCKS:    rd_d = {27'h0, unit_locks_o[ru[1:0]*5 +: 5]};
        `OFS_USER_SP:  rd_d = 32'h0;
        default:       rd_d = {7'h0, mode_oh[ru[1:0]], 16'h0, fan_oh[ru[1:0]]};
      endcase
    end else if (s_axi_araddr == `OFS_LINK) begin
      rd_d = {second_link_q(l2_s2_q), first_link_q(l1_s2_q)};
    end
  end

  // Link status passes through unchanged; 256 marks a lost link.
  function [15:0] first_link_q;
    input [15:0] v;
    begin
      first_link_q = v;
    end
  endfunction
  function [15:0] second_link_q;
    input [15:0] v;
    begin
      second_link_q = v;
    end
  endfunction

  // Read answer is registered at acceptance and stands until rready is seen.
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_d;
      s_axi_rresp  <= (ru == 3'h7 && s_axi_araddr != `OFS_LINK) ? 2'h2 : 2'h0;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// ---- sim/hvac_map_props.sv ----
// Purpose: Port-level checks on bus timing and unit outputs of the setpoint map.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Sees the top module's ports only.
`timescale 1ns/1ns
module hvac_map_props (
  input logic        sys_clk_i,
  input logic        reset_i,
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic [1:0]  s_axi_bresp,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic [31:0] virtual_setpoint_out_o,
  input logic [11:0] unit_mode_o,
  input logic [3:0]  filter_clear_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  // Every unit byte must stay inside the setpoint range whatever the inputs did.
  function automatic bit sp_ok(input logic [31:0] v);
    sp_ok = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if ($signed(v[8*i+:8]) < -15 || $signed(v[8*i+:8]) > 60) sp_ok = 1'b0;
    end
  endfunction
  // Only the five documented mode codes may ever reach a unit.
  function automatic bit mode_ok(input logic [11:0] v);
    mode_ok = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (v[3*i+:3] > 3'h4) mode_ok = 1'b0;
    end
  endfunction
  // Both write channels meeting on one edge, then the answer two edges later.
  sequence both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence resp_second;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  a_write_resp_time: assert property (both_taken |=> resp_second)
    else $error("write response not two cycles after accept");
  a_read_resp_time: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not one cycle after accept");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  a_one_read: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid) && $past(s_axi_arready))
    else $error("read answer without an accepted address");
  a_one_write: assert property ($rose(s_axi_bvalid) |-> !$past(s_axi_awready) && !$past(s_axi_wready))
    else $error("write answer while a channel was still open");
  a_clear_pulse: assert property (filter_clear_o != 4'h0 |=> filter_clear_o == 4'h0)
    else $error("filter clear longer than one cycle");
  a_sp_clamped: assert property (sp_ok(virtual_setpoint_out_o))
    else $error("unit setpoint outside range");
  a_sp_reset: assert property ($fell(reset_i) |-> virtual_setpoint_out_o == 32'h16161616)
    else $error("setpoint not at reset value");
  a_mode_legal: assert property (mode_ok(unit_mode_o))
    else $error("illegal mode code");
endmodule
bind hvac_datapoint_setpoint_map hvac_map_props u_props (.sys_clk_i, .reset_i,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .virtual_setpoint_out_o, .unit_mode_o, .filter_clear_o);

// ---- sim/unit_side_model.sv ----
// Purpose: Indoor-unit side: probe temperatures, faults, filter signs, link status.
// Assumes: Values fixed for a run; all filter signs come on at reset.
// Notes:   A clear pulse drops only its own unit's sign, as a real unit would.
`timescale 1ns/1ns
module unit_side_model #(
  parameter logic [31:0] PROBE = 32'h1a121418,
  parameter logic [31:0] FAULT = 32'h00000700,
  parameter logic [15:0] LINK2 = 16'h0100
) (
  input  wire logic        sys_clk_i,
  input  wire logic        reset_i,
  input  wire logic [3:0]  filter_clear_i,
  output logic      [31:0] probe_o,
  output logic      [31:0] fault_o,
  output logic      [3:0]  sign_o,
  output logic      [15:0] link1_o,
  output logic      [15:0] link2_o
);
  logic [3:0] sign_q;
  // Each unit reports its own sensor and fault; link one is healthy, link two silent.
  assign probe_o = PROBE;
  assign fault_o = FAULT;
  assign link1_o = 16'h0000;
  assign link2_o = LINK2;
  assign sign_o  = sign_q;
  // Sign stays on until the unit sees its clear pulse.
  always @(posedge sys_clk_i) begin
    if (reset_i) sign_q <= 4'hf;
    else sign_q <= sign_q & ~filter_clear_i;
  end
endmodule

// ---- sim/hvac_datapoint_setpoint_map_tb.sv ----
// Purpose: Self-checking bench for the setpoint map over AXI4-Lite.
// Assumes: 125 MHz clock; unit side given by unit_side_model.
// Notes:   Ready is looked at on the falling edge so the rising-edge choice never races.
`timescale 1ns/1ns
module hvac_datapoint_setpoint_map_tb;
  localparam logic [1:0] OK = 2'h0;
  localparam logic [1:0] ERR = 2'h2;
  logic        sys_clk_i, reset_i, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [11:0] awaddr, araddr, mode;
  logic [31:0] wdata, rdata, probe, fault, vsp;
  logic [1:0]  bresp, rresp;
  logic [3:0]  sign, pwr, fclr, strb, lanes;
  logic [15:0] link1, link2;
  logic [7:0]  fan;
  logic [19:0] locks;
  int          mismatches = 0;
  int          total_checks = 0;
  int          cyc = 0;
  hvac_datapoint_setpoint_map dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .unit_ambient_probe_i(probe), .unit_fault_value_i(fault), .filter_sign_i(sign),
    .first_link_status_i(link1), .second_link_status_i(link2),
    .virtual_setpoint_out_o(vsp), .unit_power_o(pwr), .unit_mode_o(mode),
    .unit_fan_o(fan), .unit_locks_o(locks), .filter_clear_o(fclr));
  unit_side_model model (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .filter_clear_i(fclr),
    .probe_o(probe), .fault_o(fault), .sign_o(sign), .link1_o(link1), .link2_o(link2));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  // One write; each channel is released on the edge that takes it.
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ka, kw, kb;
    logic [1:0] r;
    @(posedge sys_clk_i);
    awaddr <= a;
    wdata <= d;
    strb <= lanes;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge sys_clk_i);
      ka = awvalid & awready;
      kw = wvalid & wready;
      kb = bvalid;
      r = bresp;
      @(posedge sys_clk_i);
      if (ka) awvalid <= 1'b0;
      if (kw) wvalid <= 1'b0;
    end while (!kb);
    bready <= 1'b0;
    chk({30'h0, r}, {30'h0, er}, "write response");
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ka, kr;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge sys_clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge sys_clk_i);
      ka = arvalid & arready;
      kr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge sys_clk_i);
      if (ka) arvalid <= 1'b0;
    end while (!kr);
    rready <= 1'b0;
    chk(d, ed, "read data");
    chk({30'h0, r}, {30'h0, er}, "read response");
  endtask
  task automatic t_setpoint();
    @(negedge sys_clk_i);
    chk(vsp, 32'h16161616, "setpoint before writes");
    rd(12'h008, 32'h16, OK);
    wr(12'h020, 32'h13, OK);
    @(negedge sys_clk_i);
    chk({24'h0, vsp[15:8]}, 32'h13, "forwarded setpoint");
    wr(12'h024, 32'h5d, OK);
    rd(12'h024, 32'h14, OK);
    wr(12'h000, 32'h14, OK);
    wr(12'h004, 32'h15, OK);
    @(negedge sys_clk_i);
    chk({24'h0, vsp[7:0]}, 32'h17, "virtual setpoint");
    rd(12'h008, 32'h17, OK);
    rd(12'h00c, 32'h18, OK);
    rd(12'h004, 32'h0, OK);
    wr(12'h004, 32'hffffffdd, OK);
    @(negedge sys_clk_i);
    chk({24'h0, vsp[7:0]}, 32'h3c, "upper clamp");
    wr(12'h000, 32'hfffffff1, OK);
    wr(12'h004, 32'h5c, OK);
    wr(12'h000, 32'h3d, OK);
    @(negedge sys_clk_i);
    chk({24'h0, vsp[7:0]}, 32'hf1, "lower clamp, range");
    $display("t_setpoint done");
  endtask
  task automatic t_unit_ctrl();
    for (int f = 0; f < 4; f++) begin
      wr(12'h070, 32'h00010000 | 32'(f), OK);
      @(negedge sys_clk_i);
      chk({30'h0, fan[7:6]}, 32'(f), "fan code");
    end
    rd(12'h062, 32'h00100008, OK);
    wr(12'h050, 32'h00010203, OK);
    rd(12'h050, 32'h00010203, OK);
    rd(12'h042, 32'h00400008, OK);
    wr(12'h040, 32'h1e, OK);
    wr(12'h03c, 32'h15, OK);
    @(negedge sys_clk_i);
    chk({24'h0, vsp[23:16]}, 32'h16, "fan mode holds setpoint");
    chk({27'h0, locks[9:5]}, 32'h15, "lock flags");
    // Lane zero off: the lock word must not move.
    lanes = 4'he;
    wr(12'h03c, 32'h0a, OK);
    lanes = 4'hf;
    rd(12'h03c, 32'h15, OK);
    $display("t_unit_ctrl done");
  endtask
  task automatic t_central();
    wr(12'h400, 32'h00001f23, OK);
    @(negedge sys_clk_i);
    chk({pwr, mode, fan, 8'h0}, {4'hf, 12'h249, 8'haa, 8'h0}, "central applied");
    chk({12'h0, locks}, 32'h000fffff, "central locks");
    wr(12'h400, 32'h0, OK);
    wr(12'h404, 32'h19, OK);
    @(negedge sys_clk_i);
    chk({20'h0, mode}, 32'h0, "central cool");
    chk({24'h0, vsp[31:24]}, 32'h19, "central setpoint");
    $display("t_central done");
  endtask
  task automatic t_status();
    rd(12'h038, 32'h7, OK);
    rd(12'h018, 32'h0, OK);
    rd(12'h408, 32'h01000000, OK);
    rd(12'h014, 32'h1, OK);
    wr(12'h014, 32'h2, OK);
    repeat (4) @(posedge sys_clk_i);
    rd(12'h014, 32'h0, OK);
    rd(12'h800, 32'h0, ERR);
    wr(12'h800, 32'h0, ERR);
    $display("t_status done");
  endtask
  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  // Cut a hang short; the whole run needs well under a thousand cycles.
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      end_sim();
    end
  end
  initial begin
    {reset_i, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
    {awaddr, araddr, wdata} = '0;
    {strb, lanes} = 8'hff;
    repeat (2) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    t_setpoint();
    t_unit_ctrl();
    t_central();
    t_status();
    end_sim();
  end
endmodule
